/* File: hw/combo_hold.sv */
// One-shot detector for a key combination held for a fixed time
`timescale 1ns/1ps
module combo_hold #(
    parameter int unsigned HOLD = supervisor_pkg::HOLD_CYC
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic combo,
    output logic      fire
);
    import supervisor_pkg::*;

    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic        spent_reg;
    logic        spent_next;

    // Count while held, fire once, re-arm only on full release
    always_comb begin
        cnt_next   = cnt_reg;
        spent_next = spent_reg;
        fire       = 1'b0;
        if (!combo) begin
            cnt_next   = 32'h0;
            spent_next = 1'b0;
        end else if (!spent_reg) begin
            if (cnt_reg == 32'(HOLD - 1)) begin
                fire       = 1'b1;
                spent_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 32'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg   <= 32'h0;
            spent_reg <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            spent_reg <= spent_next;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_fire_after_hold;
        fire |-> combo && $past(combo) && cnt_reg == 32'(HOLD - 1);
    endproperty
    a_fire_after_hold: assert property (p_fire_after_hold) else $error("fire without full hold");

    property p_no_early_fire;
        $rose(combo) |-> !fire [*2];
    endproperty
    a_no_early_fire: assert property (p_no_early_fire) else $error("fire right after press");

    property p_once_per_press;
        fire ##1 combo |-> !fire;
    endproperty
    a_once_per_press: assert property (p_once_per_press) else $error("second fire in one press");
endmodule

/* File: hw/keyboard_supervisor_reset_rtc.sv */
// Supervisor: power-on reset, key-driven interrupt and reset, time counter, parameter store, bus master
//
// Contract
// - On sensing supply power come on, hold the system reset output long enough for the processor to settle.
// - Power key plus command key held together raises the interrupt request toward the processor.
// - Command, control and power keys held together force a reset identical to the power-on reset.
// - A combination must be held at least one second; shorter presses do nothing.
// - A 32-bit time counter advances once per second like a real-time clock.
// - On battery alone the time counter keeps running and the parameter store is left unchanged.
// - The host reaches the time counter and parameter store only through commands that this block decodes.
// - This block is sole master of the single-wire input bus, driving it and reading back the selected device.
`timescale 1ns/1ps
module keyboard_supervisor_reset_rtc #(
    parameter int unsigned POR_LEN  = supervisor_pkg::POR_CYC,
    parameter int unsigned HOLD_LEN = supervisor_pkg::HOLD_CYC,
    parameter int unsigned TICK_LEN = supervisor_pkg::TICK_CYC,
    parameter int unsigned ATTN_LEN = supervisor_pkg::ATTN_CYC,
    parameter int unsigned RXTO_LEN = supervisor_pkg::RX_TO_CYC,
    parameter int unsigned POLL_LEN = supervisor_pkg::POLL_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        power_good,
    input  wire logic        power_key_line_n,
    input  wire logic        pib_in,
    output logic             pib_out,
    output logic             pib_oe,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_write,
    input  wire logic        cmd_time,
    input  wire logic [7:0]  cmd_addr,
    input  wire logic [31:0] cmd_wdata,
    output logic             rsp_valid,
    output logic [31:0]      rsp_data,
    output logic             sys_reset_n,
    output logic             nmi_n
);
    import supervisor_pkg::*;

    typedef enum logic [2:0] {
        B_IDLE   = 3'b000,
        B_ATTN   = 3'b001,
        B_SYNC   = 3'b010,
        B_TXLO   = 3'b011,
        B_TXHI   = 3'b100,
        B_RXWAIT = 3'b101,
        B_RXLO   = 3'b110,
        B_RXHI   = 3'b111
    } bus_state_e;

    // Reset release through two flops; battery reset only
    logic rst_meta_reg;
    logic rst_n;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // ---------------- Input bus master ----------------
    bus_state_e  st_reg, st_next;
    logic [31:0] bcnt_reg, bcnt_next;
    logic [4:0]  bit_reg, bit_next;
    logic [8:0]  tx_reg, tx_next;
    logic [16:0] rx_reg, rx_next;
    logic        cmd_key_reg, cmd_key_next;
    logic        ctrl_key_reg, ctrl_key_next;
    logic [31:0] low_len;

    assign low_len = tx_reg[8] ? 32'(LOW1_CYC) : 32'(LOW0_CYC);

    // Poll the keyboard modifier register; only while main power is up
    always_comb begin
        st_next       = st_reg;
        bcnt_next     = bcnt_reg + 32'h1;
        bit_next      = bit_reg;
        tx_next       = tx_reg;
        rx_next       = rx_reg;
        cmd_key_next  = cmd_key_reg;
        ctrl_key_next = ctrl_key_reg;
        pib_oe        = 1'b0;
        unique case (st_reg)
            B_IDLE: if (bcnt_reg >= 32'(POLL_LEN - 1)) begin
                st_next   = B_ATTN;
                bcnt_next = 32'h0;
            end
            B_ATTN: begin
                pib_oe = 1'b1;
                if (bcnt_reg == 32'(ATTN_LEN - 1)) begin
                    st_next   = B_SYNC;
                    bcnt_next = 32'h0;
                end
            end
            B_SYNC: if (bcnt_reg == 32'(SYNC_CYC - 1)) begin
                st_next   = B_TXLO;
                bcnt_next = 32'h0;
                tx_next   = {KBD_TALK_MOD, 1'b0};       // Command then stop bit
                bit_next  = 5'h0;
            end
            B_TXLO: begin
                pib_oe = 1'b1;
                if (bcnt_reg == low_len - 32'h1) begin
                    st_next = B_TXHI;
                end
            end
            B_TXHI: if (bcnt_reg == 32'(CELL_CYC - 1)) begin
                bcnt_next = 32'h0;
                tx_next   = {tx_reg[7:0], 1'b0};
                bit_next  = bit_reg + 5'h1;
                st_next   = (bit_reg == 5'(TX_BITS - 1)) ? B_RXWAIT : B_TXLO;
                if (bit_reg == 5'(TX_BITS - 1)) begin
                    bit_next = 5'h0;
                end
            end
            B_RXWAIT: if (!pib_in) begin
                st_next   = B_RXLO;
                bcnt_next = 32'h0;
            end else if (bcnt_reg == 32'(RXTO_LEN - 1)) begin
                st_next   = B_IDLE;                     // Silent device: keep old keys
                bcnt_next = 32'h0;
            end
            B_RXLO: if (pib_in) begin
                rx_next   = {rx_reg[15:0], (bcnt_reg < 32'(THRESH_CYC))};
                bit_next  = bit_reg + 5'h1;
                bcnt_next = 32'h0;
                st_next   = B_RXHI;
                if (bit_reg == 5'(RX_BITS - 1)) begin
                    // Start bit ends in the top bit; modifiers read active low
                    cmd_key_next  = ~rx_reg[KEY_CMD_BIT - 1];
                    ctrl_key_next = ~rx_reg[KEY_CTRL_BIT - 1];
                    if (KEY_CMD_BIT == 0) cmd_key_next = ~pib_in;
                    st_next = B_IDLE;
                end
            end
            B_RXHI: if (!pib_in) begin
                st_next   = B_RXLO;
                bcnt_next = 32'h0;
            end else if (bcnt_reg == 32'(CELL_CYC - 1)) begin
                st_next   = B_IDLE;                     // Truncated reply dropped
                bcnt_next = 32'h0;
            end
        endcase
        if (!power_good) begin
            st_next       = B_IDLE;
            bcnt_next     = 32'h0;
            cmd_key_next  = 1'b0;
            ctrl_key_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg       <= B_IDLE;
            bcnt_reg     <= 32'h0;
            bit_reg      <= 5'h0;
            tx_reg       <= 9'h0;
            rx_reg       <= 17'h0;
            cmd_key_reg  <= 1'b0;
            ctrl_key_reg <= 1'b0;
        end else begin
            st_reg       <= st_next;
            bcnt_reg     <= bcnt_next;
            bit_reg      <= bit_next;
            tx_reg       <= tx_next;
            rx_reg       <= rx_next;
            cmd_key_reg  <= cmd_key_next;
            ctrl_key_reg <= ctrl_key_next;
        end
    end

    // Open-drain: only ever pulls low
    assign pib_out = 1'b0;

    // ---------------- Key combinations ----------------
    logic       pwr_key;
    logic [1:0] combo;
    logic [1:0] fire;
    assign pwr_key  = ~power_key_line_n;
    // Control excluded from the interrupt combo so a reset press never also interrupts
    assign combo[0] = pwr_key & cmd_key_reg & ~ctrl_key_reg;
    assign combo[1] = pwr_key & cmd_key_reg & ctrl_key_reg;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_combo
            combo_hold #(.HOLD(HOLD_LEN)) u_hold (
                .clk_sys (clk_sys),
                .rst_n   (rst_n),
                .combo   (combo[gi]),
                .fire    (fire[gi])
            );
        end
    endgenerate

    // ---------------- Reset and interrupt outputs ----------------
    logic [31:0] por_reg, por_next;
    logic        srst_reg, srst_next;
    logic [31:0] nmi_reg, nmi_next;

    // Hard reset restarts the same stretch as power-on
    always_comb begin
        por_next  = por_reg;
        srst_next = 1'b0;
        if (!power_good || fire[1]) begin
            por_next = 32'h0;
        end else if (por_reg != 32'(POR_LEN - 1)) begin
            por_next = por_reg + 32'h1;
        end else begin
            srst_next = 1'b1;
        end
        nmi_next = (nmi_reg != 32'h0) ? nmi_reg - 32'h1 : 32'h0;
        if (fire[0] && srst_reg) begin
            nmi_next = 32'(NMI_CYC);
        end
        if (!srst_reg) begin
            nmi_next = 32'h0;                            // No interrupt into a held processor
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            por_reg  <= 32'h0;
            srst_reg <= 1'b0;
            nmi_reg  <= 32'h0;
        end else begin
            por_reg  <= por_next;
            srst_reg <= srst_next;
            nmi_reg  <= nmi_next;
        end
    end

    assign sys_reset_n = srst_reg;
    assign nmi_n       = (nmi_reg == 32'h0);

    // ---------------- Time counter and parameter store ----------------
    logic [31:0] pre_reg, pre_next;
    logic [31:0] time_reg, time_next;
    logic [7:0]  param_mem [PARAM_DEPTH];
    logic        accept;
    logic        rv_next;
    logic [31:0] rd_next;
    logic        rv_reg;
    logic [31:0] rd_reg;

    // Store locked while on battery so contents cannot be disturbed
    assign cmd_ready = power_good;
    assign accept    = cmd_valid & cmd_ready;

    // Counter runs on any power, host write reloads it
    always_comb begin
        pre_next  = (pre_reg == 32'(TICK_LEN - 1)) ? 32'h0 : pre_reg + 32'h1;
        time_next = (pre_reg == 32'(TICK_LEN - 1)) ? time_reg + 32'h1 : time_reg;
        if (accept && cmd_write && cmd_time) begin
            pre_next  = 32'h0;
            time_next = cmd_wdata;
        end
        rv_next = accept && !cmd_write;
        rd_next = cmd_time ? time_reg : {24'h0, param_mem[cmd_addr]};
        if (!rv_next) begin
            rd_next = rd_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg  <= 32'h0;
            time_reg <= TIME_RST;
            rv_reg   <= 1'b0;
            rd_reg   <= 32'h0;
        end else begin
            pre_reg  <= pre_next;
            time_reg <= time_next;
            rv_reg   <= rv_next;
            rd_reg   <= rd_next;
        end
    end

    // Parameter bytes, written only through an accepted command
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < PARAM_DEPTH; i++) begin
                param_mem[i] <= PARAM_RST;
            end
        end else if (accept && cmd_write && !cmd_time) begin
            param_mem[cmd_addr] <= cmd_wdata[7:0];
        end
    end

    assign rsp_valid = rv_reg;
    assign rsp_data  = rd_reg;

    // ---------------- Checks ----------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_por_low;
        !power_good |=> !sys_reset_n;
    endproperty
    a_por_low: assert property (p_por_low) else $error("reset not held without power");

    sequence s_power_up;
        $rose(power_good);
    endsequence
    property p_por_stretch;
        s_power_up |-> !sys_reset_n [*8];
    endproperty
    a_por_stretch: assert property (p_por_stretch) else $error("reset released too soon");

    property p_nmi_raise;
        fire[0] && sys_reset_n |=> !nmi_n;
    endproperty
    a_nmi_raise: assert property (p_nmi_raise) else $error("interrupt not raised");

    property p_hard_reset;
        fire[1] |=> !sys_reset_n && por_reg == 32'h0;
    endproperty
    a_hard_reset: assert property (p_hard_reset) else $error("hard reset missing");

    property p_nmi_cause;
        $fell(nmi_n) |-> $past(fire[0]) && $past(combo[0]);
    endproperty
    a_nmi_cause: assert property (p_nmi_cause) else $error("interrupt without held combo");

    property p_tick;
        pre_reg == 32'(TICK_LEN - 1) && !(accept && cmd_write && cmd_time) |=> time_reg == $past(time_reg) + 32'h1;
    endproperty
    a_tick: assert property (p_tick) else $error("time counter missed a tick");

    // A refused read must never produce an answer one cycle later
    property p_battery_lock;
        !power_good |-> !cmd_ready ##1 !rsp_valid;
    endproperty
    a_battery_lock: assert property (p_battery_lock) else $error("store open on battery");

    property p_read_answer;
        accept && !cmd_write && cmd_time |=> rsp_valid && rsp_data == $past(time_reg);
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("bad time read answer");

    property p_bus_drive;
        st_reg inside {B_ATTN, B_TXLO} |-> pib_oe;
    endproperty
    a_bus_drive: assert property (p_bus_drive) else $error("attention not driven");

    property p_bus_listen;
        st_reg inside {B_RXWAIT, B_RXLO, B_RXHI, B_SYNC} |-> !pib_oe;
    endproperty
    a_bus_listen: assert property (p_bus_listen) else $error("master drove bus while listening");
endmodule

/* File: hw/supervisor_pkg.sv */
// Shared constants for the keyboard supervisor: timing, bus command, key bits, store size
package supervisor_pkg;
    // System clock
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned CLK_MHZ         = CLK_HZ / 1_000_000;

    // Key combination hold time, whole seconds
    localparam int unsigned HOLD_S          = 1;
    localparam int unsigned HOLD_CYC        = HOLD_S * CLK_HZ;
    // Time counter tick period, whole seconds
    localparam int unsigned TICK_S          = 1;
    localparam int unsigned TICK_CYC        = TICK_S * CLK_HZ;
    // Power-on reset stretch, milliseconds
    localparam int unsigned POR_MS          = 250;
    localparam int unsigned POR_CYC         = POR_MS * (CLK_HZ / 1000);
    // Interrupt request pulse, microseconds
    localparam int unsigned NMI_US          = 10;
    localparam int unsigned NMI_CYC         = NMI_US * CLK_MHZ;

    // Peripheral input bus timing, microseconds
    localparam int unsigned ATTN_US         = 800;
    localparam int unsigned ATTN_CYC        = ATTN_US * CLK_MHZ;
    localparam int unsigned SYNC_US         = 70;
    localparam int unsigned SYNC_CYC        = SYNC_US * CLK_MHZ;
    localparam int unsigned CELL_US         = 100;
    localparam int unsigned CELL_CYC        = CELL_US * CLK_MHZ;
    localparam int unsigned LOW0_US         = 65;
    localparam int unsigned LOW0_CYC        = LOW0_US * CLK_MHZ;
    localparam int unsigned LOW1_US         = 35;
    localparam int unsigned LOW1_CYC        = LOW1_US * CLK_MHZ;
    localparam int unsigned THRESH_US       = 50;
    localparam int unsigned THRESH_CYC      = THRESH_US * CLK_MHZ;
    localparam int unsigned RX_TO_US        = 300;
    localparam int unsigned RX_TO_CYC       = RX_TO_US * CLK_MHZ;
    localparam int unsigned POLL_US         = 11_000;
    localparam int unsigned POLL_CYC        = POLL_US * CLK_MHZ;

    // Poll command: talk, keyboard address, modifier register
    localparam logic [7:0]  KBD_TALK_MOD    = 8'h2e;
    localparam int unsigned TX_BITS         = 9;
    localparam int unsigned RX_BITS         = 17;
    // Modifier bit positions in the reply word, active low
    localparam int unsigned KEY_CMD_BIT     = 8;
    localparam int unsigned KEY_CTRL_BIT    = 3;

    // Parameter store
    localparam int unsigned PARAM_DEPTH     = 256;
    localparam logic [31:0] TIME_RST        = 32'h0000_0000;
    localparam logic [7:0]  PARAM_RST       = 8'h00;
endpackage

/* File: testbench/keyboard_supervisor_reset_rtc_tb.sv */
// Self-checking bench for the keyboard supervisor
`timescale 1ns/1ps
module keyboard_supervisor_reset_rtc_tb;
    import supervisor_pkg::*;
    localparam int POR  = 20;
    localparam int HOLD = 50;
    logic        clk_sys          = 1'b0;
    logic        resetn           = 1'b0;
    logic        power_good       = 1'b1;
    logic        power_key_line_n = 1'b1;
    logic        cmd_valid        = 1'b0;
    logic        cmd_write        = 1'b0;
    logic        cmd_time         = 1'b0;
    logic [7:0]  cmd_addr         = 8'h00;
    logic [31:0] cmd_wdata        = 32'h0;
    logic [15:0] key_word         = 16'hfeff;
    logic        pib_oe, cmd_ready, rsp_valid, sys_reset_n, nmi_n, kbd_pull, nmi_q, rst_q;
    logic [31:0] rsp_data, t0, w;
    logic [7:0]  cmd_seen, pd[3];
    logic [7:0]  pa[3]            = '{8'h00, 8'hff, 8'h81};
    logic [31:0] exp_q[$];
    int          err_total = 0, compares = 0, replies, cyc = 0, n, nmi_falls = 0, rst_falls = 0;
    wire         bus_line = ~(pib_oe | kbd_pull); // Pull-up when released

    keyboard_supervisor_reset_rtc #(.POR_LEN(POR), .HOLD_LEN(HOLD), .TICK_LEN(10), .ATTN_LEN(20),
        .RXTO_LEN(6000), .POLL_LEN(100)) dut_u (
        .clk_sys(clk_sys), .resetn(resetn), .power_good(power_good), .power_key_line_n(power_key_line_n),
        .pib_in(bus_line), .pib_out(), .pib_oe(pib_oe), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_write(cmd_write), .cmd_time(cmd_time), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .sys_reset_n(sys_reset_n), .nmi_n(nmi_n));

    pib_keyboard_model kbd_u (.clk_sys(clk_sys), .bus_line(bus_line), .key_word(key_word),
        .pull(kbd_pull), .cmd_seen(cmd_seen), .replies(replies));

    always #25 clk_sys = ~clk_sys;

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Bus cycles: one request per edge, held until the next edge
    task automatic cmd(input logic wr, input logic tm, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_time  <= tm;
        cmd_addr  <= a;
        cmd_wdata <= d;
    endtask

    task automatic rd(input logic tm, input logic [7:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        cmd(1'b0, tm, a, 32'h0);
    endtask

    task automatic idle(input int k);
        repeat (k) begin
            @(posedge clk_sys);
            cmd_valid <= 1'b0;
        end
    endtask

    task automatic key(input logic v);
        @(posedge clk_sys);
        power_key_line_n <= v;
    endtask

    // Wait for reset release, bounded at 1000 cycles, and for keyboard replies, unbounded
    task automatic rst_len(output int c);
        c = 0;
        while (sys_reset_n !== 1'b1 && c < 1000) begin
            @(posedge clk_sys);
            c++;
        end
    endtask

    task automatic wait_reply(input int k);
        while (replies < k) @(posedge clk_sys);
        idle(10);
    endtask

    // Watchdog and edge counters; the hang limit covers two full polls
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        nmi_q <= nmi_n;
        rst_q <= sys_reset_n;
        if (nmi_q === 1'b1 && nmi_n === 1'b0) nmi_falls++;
        if (rst_q === 1'b1 && sys_reset_n === 1'b0) rst_falls++;
        if (cyc == 100000) begin
            err_total++;
            print_verdict();
        end
    end

    // Each read response retires the oldest note
    always @(posedge clk_sys) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) chk("rsp_extra", 32'h1, 32'h0);
            else chk("rsp_data", rsp_data, exp_q.pop_front());
        end
    end

    initial begin
        void'($urandom(32'h69ec));
        t0 = $urandom();
        w = $urandom();
        repeat (4) @(posedge clk_sys);
        chk("sys_reset_n", sys_reset_n, 32'h0);
        resetn <= 1'b1;
        rst_len(n);
        chk("por_len", n >= POR && n <= POR + 4, 32'h1);
        // Power lost mid-count: refused write, clock keeps running
        cmd(1'b1, 1'b0, 8'h20, w);
        cmd(1'b1, 1'b1, 8'h00, t0);
        idle(1);
        @(posedge clk_sys) power_good <= 1'b0;
        cmd(1'b1, 1'b0, 8'h10, 32'h3c);
        #1 chk("cmd_ready", cmd_ready, 32'h0);
        idle(1);
        chk("sys_reset_n", sys_reset_n, 32'h0);
        idle(35);
        @(posedge clk_sys) power_good <= 1'b1;
        idle(15);
        rd(1'b1, 8'h00, t0 + 32'd5);
        rd(1'b0, 8'h10, 32'h0);
        rd(1'b0, 8'h20, {24'h0, w[7:0]});
        // Counter steps once per tick and wraps at 32 bits
        cmd(1'b1, 1'b1, 8'h00, 32'hffff_fffe);
        idle(4);
        rd(1'b1, 8'h00, 32'hffff_fffe);
        idle(9);
        rd(1'b1, 8'h00, 32'hffff_ffff);
        idle(9);
        rd(1'b1, 8'h00, 32'h0);
        // Store bytes at both ends of the range, back to back
        for (int i = 0; i < 3; i++) begin
            w = $urandom();
            pd[i] = w[7:0];
            cmd(1'b1, 1'b0, pa[i], w);
        end
        for (int i = 0; i < 3; i++) rd(1'b0, pa[i], {24'h0, pd[i]});
        idle(3);
        wait_reply(1);
        chk("poll_cmd", cmd_seen, KBD_TALK_MOD);
        key_word <= 16'hfef7;
        // Interrupt: short press ignored, one pulse per press, re-arm
        key(1'b0);
        idle(HOLD - 10);
        key(1'b1);
        idle(20);
        chk("nmi_falls", nmi_falls, 32'h0);
        key(1'b0);
        idle(HOLD - 3);
        chk("nmi_n", nmi_n, 32'h1);
        idle(6);
        chk("nmi_n", nmi_n, 32'h0);
        idle(150);
        chk("nmi_n", nmi_n, 32'h0);
        idle(60);
        chk("nmi_n", nmi_n, 32'h1);
        idle(3 * HOLD);
        chk("nmi_falls", nmi_falls, 32'h1);
        chk("sys_reset_n", sys_reset_n, 32'h1);
        key(1'b1);
        idle(5);
        key(1'b0);
        idle(HOLD + 5);
        chk("nmi_falls", nmi_falls, 32'h2);
        key(1'b1);
        idle(250);
        // Hard reset with control also down
        wait_reply(2);
        key(1'b0);
        n = 0;
        while (sys_reset_n === 1'b1 && n < 500) begin
            @(posedge clk_sys);
            n++;
        end
        chk("hold_len", n >= HOLD - 1 && n <= HOLD + 3, 32'h1);
        rst_len(n);
        chk("hard_len", n >= POR - 1 && n <= POR + 1, 32'h1);
        idle(3 * HOLD);
        chk("rst_falls", rst_falls, 32'h2);
        chk("nmi_falls", nmi_falls, 32'h2);
        key(1'b1);
        idle(5);
        chk("pending", exp_q.size(), 32'h0);
        print_verdict();
    end
endmodule

/* File: testbench/pib_keyboard_model.sv */
// Keyboard device model answering polls on the single-wire input bus
`timescale 1ns/1ps
module pib_keyboard_model (
    input  wire logic        clk_sys,
    input  wire logic        bus_line,
    input  wire logic [15:0] key_word,
    output logic             pull,
    output logic [7:0]       cmd_seen,
    output int               replies
);
    int   lo;
    logic bit_v;

    initial begin
        pull = 1'b0;
        cmd_seen = 8'h00;
        replies = 0;
    end

    // Listen to attention and command, answer every command without checking its address
    always begin
        @(negedge bus_line);
        @(posedge bus_line);
        for (int i = 0; i < 9; i++) begin
            @(negedge bus_line);
            lo = 0;
            while (bus_line === 1'b0) begin
                @(posedge clk_sys);
                lo++;
            end
            if (i < 8) cmd_seen = {cmd_seen[6:0], lo < 1000};
        end
        // Wait out the master's stop cell before the start bit
        repeat (900) @(posedge clk_sys);
        // Start bit then word MSB first; 80 us cells keep the run short
        for (int k = 0; k < 17; k++) begin
            bit_v = (k == 0) ? 1'b1 : key_word[16-k];
            pull <= 1'b1;
            repeat (bit_v ? 500 : 1100) @(posedge clk_sys);
            pull <= 1'b0;
            // Last cell ends on release so the next attention is not missed
            if (k < 16) repeat (bit_v ? 1100 : 500) @(posedge clk_sys);
        end
        replies <= replies + 1;
    end
endmodule
